/* logic/sgs_defines.svh */
`ifndef SGS_DEFINES_SVH
`define SGS_DEFINES_SVH

// Register byte offsets
`define SGS_OFS_CONFIG      8'h00
`define SGS_OFS_WAIT1       8'h04
`define SGS_OFS_WAIT2       8'h08
`define SGS_OFS_RAMP1       8'h0c
`define SGS_OFS_RAMP2       8'h10
`define SGS_OFS_STATUS      8'h14
`define SGS_OFS_SET1_BASE   8'h20
`define SGS_OFS_SET2_BASE   8'h40
`define SGS_NUM_PARAMS      7

// Fields of gain_switch_config
`define SGS_MODE_LSB        0
`define SGS_COND_LSB        4
`define SGS_MODE_MANUAL     4'h0
`define SGS_MODE_AUTO       4'h2
`define SGS_CONFIG_RESET    16'h0000

// Loop structure codes that allow automatic switching
`define SGS_LOOP_PI         2'h0
`define SGS_LOOP_IP         2'h1

// Timing: 1 ms step at 10 MHz
`define SGS_CLK_HZ          10000000
`define SGS_STEP_MS         1
`define SGS_STEP_CYCLES     (`SGS_CLK_HZ / 1000 * `SGS_STEP_MS)
`define SGS_TIME_RESET      16'h0000

// Reset values of each gain parameter, both sets
`define SGS_RST_SPEED_GAIN  16'h0190
`define SGS_RST_SPEED_INTEG 16'h07d0
`define SGS_RST_POS_GAIN    16'h0190
`define SGS_RST_TORQUE_FILT 16'h0064
`define SGS_RST_MF_GAIN     16'h01f4
`define SGS_RST_MF_COMP     16'h03e8
`define SGS_RST_FRICTION    16'h0064

// Parameter indices within a set
`define SGS_IDX_MF_GAIN     4
`define SGS_IDX_MF_COMP     5

`define SGS_RESP_OKAY       2'h0
`define SGS_RESP_SLVERR     2'h2

`endif

/* logic/sgs_pkg.sv */
package sgs_pkg;

  typedef struct packed {
    logic [15:0] friction_gain;
    logic [15:0] mf_comp;
    logic [15:0] mf_gain;
    logic [15:0] torque_filt;
    logic [15:0] pos_gain;
    logic [15:0] speed_integ;
    logic [15:0] speed_gain;
  } sgs_gain_set_t;

  typedef struct packed {
    logic pos_complete;
    logic near_pos;
    logic ref_filter_idle;
    logic ref_input_on;
  } sgs_pos_status_t;

  typedef enum logic [2:0] {
    SGS_HOLD1,
    SGS_WAIT_UP,
    SGS_RAMP_UP,
    SGS_HOLD2,
    SGS_WAIT_DN,
    SGS_RAMP_DN
  } sgs_state_t;

endpackage

/* logic/sgs_switcher.sv */
`timescale 1ns/1ps
`include "sgs_defines.svh"

module sgs_switcher #(
  parameter int unsigned P_STEP_CYCLES = `SGS_STEP_CYCLES
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst,
  input  wire logic [7:0]               i_s_axi_awaddr,
  input  wire logic                     i_s_axi_awvalid,
  output logic                          o_s_axi_awready,
  input  wire logic [31:0]              i_s_axi_wdata,
  input  wire logic [3:0]               i_s_axi_wstrb,
  input  wire logic                     i_s_axi_wvalid,
  output logic                          o_s_axi_wready,
  output logic [1:0]                    o_s_axi_bresp,
  output logic                          o_s_axi_bvalid,
  input  wire logic                     i_s_axi_bready,
  input  wire logic [7:0]               i_s_axi_araddr,
  input  wire logic                     i_s_axi_arvalid,
  output logic                          o_s_axi_arready,
  output logic [31:0]                   o_s_axi_rdata,
  output logic [1:0]                    o_s_axi_rresp,
  output logic                          o_s_axi_rvalid,
  input  wire logic                     i_s_axi_rready,
  input  wire logic                     i_gain_sel,
  input  wire logic                     i_cmd_busy,
  input  wire logic                     i_motor_stopped,
  input  wire logic                     i_position_ctrl,
  input  wire sgs_pkg::sgs_pos_status_t i_pos_status,
  input  wire logic [1:0]               i_loop_structure_select,
  output sgs_pkg::sgs_gain_set_t        o_active_gains,
  output logic                          o_set2_active,
  output logic                          o_ramping
);
  import sgs_pkg::*;

  logic [15:0]      gain_switch_config;
  logic [15:0]      switch_wait_time_first;
  logic [15:0]      switch_wait_time_second;
  logic [15:0]      switch_ramp_time_first;
  logic [15:0]      switch_ramp_time_second;
  logic [15:0]      gain_reg [2][`SGS_NUM_PARAMS];
  sgs_state_t       state;
  sgs_state_t       next_state;
  logic [31:0]      step_cnt;
  logic             step_tick;
  logic [15:0]      ms_cnt;
  logic             mf_sel;
  logic             gain_sel_prev;
  logic [3:0]       mode;
  logic [3:0]       cond_code;
  logic             auto_on;
  logic             cond_a;
  logic             fixed_set;
  logic             cur_set;
  logic             ramp_from;
  logic [15:0]      ramp_len;
  logic             in_ramp;
  logic             wr_go;
  logic [4:0]       aw_slot;
  logic [4:0]       ar_slot;
  logic [15:0]      wr_val;
  logic [15:0]      next_gain [`SGS_NUM_PARAMS];
  sgs_gain_set_t    next_active;

  // Byte lanes 0 and 1 only; upper lanes fall on always-zero bits
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = d[7:0];
    end
    if (strb[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Gain parameter slot decode: hit, set bit, index
  function automatic logic [4:0] gain_slot(input logic [7:0] a);
    logic [4:0] r;
    r = 5'h00;
    if (a[1:0] == 2'h0 && a[4:2] < 3'(`SGS_NUM_PARAMS)) begin
      if (a[7:5] == 3'h1) begin
        r = {1'b1, 1'b0, a[4:2]};
      end else if (a[7:5] == 3'h2) begin
        r = {1'b1, 1'b1, a[4:2]};
      end
    end
    return r;
  endfunction

  function automatic logic cond_decode(input logic [3:0] code, input sgs_pos_status_t s);
    logic r;
    unique case (code)
      4'h0:    r = s.pos_complete;
      4'h1:    r = !s.pos_complete;
      4'h2:    r = s.near_pos;
      4'h3:    r = !s.near_pos;
      4'h4:    r = s.ref_filter_idle && !s.ref_input_on;
      4'h5:    r = s.ref_input_on;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Linear blend a -> b at k of t steps; t of zero jumps to b
  function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] k, input logic [15:0] t);
    logic signed [16:0] d;
    logic signed [33:0] p;
    logic signed [33:0] q;
    logic signed [33:0] r;
    d = $signed({1'b0, b}) - $signed({1'b0, a});
    p = d * $signed({1'b0, k});
    q = (t == 16'h0000) ? $signed({18'h00000, b}) - $signed({18'h00000, a})
                        : p / $signed({18'h00000, t});
    r = $signed({18'h00000, a}) + q;
    return r[15:0];
  endfunction

  assign mode      = gain_switch_config[`SGS_MODE_LSB +: 4];
  assign cond_code = gain_switch_config[`SGS_COND_LSB +: 4];
  assign cond_a    = cond_decode(cond_code, i_pos_status);
  assign fixed_set = cond_code[0];
  assign auto_on   = (mode == `SGS_MODE_AUTO) && i_position_ctrl
                  && (i_loop_structure_select == `SGS_LOOP_PI
                      || i_loop_structure_select == `SGS_LOOP_IP);

  assign aw_slot         = gain_slot(i_s_axi_awaddr);
  assign wr_go           = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid;
  assign o_s_axi_awready = wr_go;
  assign o_s_axi_wready  = wr_go;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `SGS_RESP_OKAY;
    end else if (wr_go) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp  <= (aw_slot[4]
                         || i_s_axi_awaddr == `SGS_OFS_CONFIG
                         || i_s_axi_awaddr == `SGS_OFS_WAIT1
                         || i_s_axi_awaddr == `SGS_OFS_WAIT2
                         || i_s_axi_awaddr == `SGS_OFS_RAMP1
                         || i_s_axi_awaddr == `SGS_OFS_RAMP2
                         || i_s_axi_awaddr == `SGS_OFS_STATUS) ? `SGS_RESP_OKAY
                                                                : `SGS_RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      gain_switch_config      <= `SGS_CONFIG_RESET;
      switch_wait_time_first  <= `SGS_TIME_RESET;
      switch_wait_time_second <= `SGS_TIME_RESET;
      switch_ramp_time_first  <= `SGS_TIME_RESET;
      switch_ramp_time_second <= `SGS_TIME_RESET;
    end else if (wr_go) begin
      unique case (i_s_axi_awaddr)
        `SGS_OFS_CONFIG: gain_switch_config      <= merge16(gain_switch_config,
                                                            i_s_axi_wdata, i_s_axi_wstrb);
        `SGS_OFS_WAIT1:  switch_wait_time_first  <= merge16(switch_wait_time_first,
                                                            i_s_axi_wdata, i_s_axi_wstrb);
        `SGS_OFS_WAIT2:  switch_wait_time_second <= merge16(switch_wait_time_second,
                                                            i_s_axi_wdata, i_s_axi_wstrb);
        `SGS_OFS_RAMP1:  switch_ramp_time_first  <= merge16(switch_ramp_time_first,
                                                            i_s_axi_wdata, i_s_axi_wstrb);
        `SGS_OFS_RAMP2:  switch_ramp_time_second <= merge16(switch_ramp_time_second,
                                                            i_s_axi_wdata, i_s_axi_wstrb);
        default: ;
      endcase
    end
  end

  // Both gain sets are stored; reset values identical for set 1 and set 2
  genvar gs, gp;
  generate
    for (gs = 0; gs < 2; gs++) begin : g_set
      for (gp = 0; gp < `SGS_NUM_PARAMS; gp++) begin : g_par
        localparam logic [15:0] RST_VAL [`SGS_NUM_PARAMS] = '{
          `SGS_RST_SPEED_GAIN, `SGS_RST_SPEED_INTEG, `SGS_RST_POS_GAIN,
          `SGS_RST_TORQUE_FILT, `SGS_RST_MF_GAIN, `SGS_RST_MF_COMP, `SGS_RST_FRICTION};
        always_ff @(posedge i_mclk) begin
          if (i_rst) begin
            gain_reg[gs][gp] <= RST_VAL[gp];
          end else if (wr_go && gain_slot(i_s_axi_awaddr) == {1'b1, 1'(gs), 3'(gp)}) begin
            gain_reg[gs][gp] <= merge16(gain_reg[gs][gp], i_s_axi_wdata, i_s_axi_wstrb);
          end
        end
      end
    end
  endgenerate

  assign ar_slot         = gain_slot(i_s_axi_araddr);
  assign o_s_axi_arready = !o_s_axi_rvalid;
  assign wr_val = gain_reg[ar_slot[3]][ar_slot[2:0]];

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h00000000;
      o_s_axi_rresp  <= `SGS_RESP_OKAY;
    end else if (i_s_axi_arvalid && !o_s_axi_rvalid) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= `SGS_RESP_OKAY;
      unique case (i_s_axi_araddr)
        `SGS_OFS_CONFIG: o_s_axi_rdata <= {16'h0000, gain_switch_config};
        `SGS_OFS_WAIT1:  o_s_axi_rdata <= {16'h0000, switch_wait_time_first};
        `SGS_OFS_WAIT2:  o_s_axi_rdata <= {16'h0000, switch_wait_time_second};
        `SGS_OFS_RAMP1:  o_s_axi_rdata <= {16'h0000, switch_ramp_time_first};
        `SGS_OFS_RAMP2:  o_s_axi_rdata <= {16'h0000, switch_ramp_time_second};
        `SGS_OFS_STATUS: o_s_axi_rdata <= {8'h00, ms_cnt, 1'b0, 3'(state),
                                           auto_on, mf_sel, o_ramping, o_set2_active};
        default: begin
          if (ar_slot[4]) begin
            o_s_axi_rdata <= {16'h0000, wr_val};
          end else begin
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= `SGS_RESP_SLVERR;
          end
        end
      endcase
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  assign step_tick = (step_cnt == P_STEP_CYCLES - 1);

  // Step phase restarts with every state change so each wait starts whole
  always_ff @(posedge i_mclk) begin
    if (i_rst || next_state != state || step_tick) begin
      step_cnt <= 32'h00000000;
    end else begin
      step_cnt <= step_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || next_state != state) begin
      ms_cnt <= 16'h0000;
    end else if (step_tick && ms_cnt != 16'hffff) begin
      ms_cnt <= ms_cnt + 16'h0001;
    end
  end

  always_comb begin
    next_state = state;
    if (!auto_on) begin
      // Parked on the fixed set (manual mode: the set on the select bit) so a return to auto starts settled
      if (mode == `SGS_MODE_AUTO) begin
        next_state = fixed_set ? SGS_HOLD2 : SGS_HOLD1;
      end else begin
        next_state = i_gain_sel ? SGS_HOLD2 : SGS_HOLD1;
      end
    end else begin
      unique case (state)
        SGS_HOLD1:   if (cond_a) next_state = SGS_WAIT_UP;
        SGS_WAIT_UP: begin
          if (!cond_a) begin
            next_state = SGS_HOLD1;
          end else if (ms_cnt >= switch_wait_time_first) begin
            next_state = SGS_RAMP_UP;
          end
        end
        SGS_RAMP_UP: if (ms_cnt >= switch_ramp_time_first) next_state = SGS_HOLD2;
        SGS_HOLD2:   if (!cond_a) next_state = SGS_WAIT_DN;
        SGS_WAIT_DN: begin
          if (cond_a) begin
            next_state = SGS_HOLD2;
          end else if (ms_cnt >= switch_wait_time_second) begin
            next_state = SGS_RAMP_DN;
          end
        end
        SGS_RAMP_DN: if (ms_cnt >= switch_ramp_time_second) next_state = SGS_HOLD1;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= SGS_HOLD1;
    end else begin
      state <= next_state;
    end
  end

  // Edge of the select bit is the request; a request while moving is dropped
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      gain_sel_prev <= 1'b0;
      mf_sel        <= 1'b0;
    end else begin
      gain_sel_prev <= i_gain_sel;
      if (mode != `SGS_MODE_AUTO && i_gain_sel != gain_sel_prev
          && !i_cmd_busy && i_motor_stopped) begin
        mf_sel <= i_gain_sel;
      end
    end
  end

  assign in_ramp   = (state == SGS_RAMP_UP) || (state == SGS_RAMP_DN);
  assign ramp_from = (state == SGS_RAMP_DN);
  assign ramp_len  = ramp_from ? switch_ramp_time_second : switch_ramp_time_first;

  always_comb begin
    if (mode != `SGS_MODE_AUTO) begin
      cur_set = i_gain_sel;
    end else if (!auto_on) begin
      cur_set = fixed_set;
    end else begin
      cur_set = (state == SGS_HOLD2) || (state == SGS_WAIT_DN);
    end
  end

  generate
    for (gp = 0; gp < `SGS_NUM_PARAMS; gp++) begin : g_out
      always_comb begin
        if (gp == `SGS_IDX_MF_GAIN || gp == `SGS_IDX_MF_COMP) begin
          next_gain[gp] = gain_reg[mf_sel][gp];
        end else if (auto_on && in_ramp) begin
          next_gain[gp] = lerp(gain_reg[ramp_from][gp], gain_reg[!ramp_from][gp],
                               ms_cnt, ramp_len);
        end else begin
          next_gain[gp] = gain_reg[cur_set][gp];
        end
      end
    end
  endgenerate

  assign next_active = '{friction_gain: next_gain[6], mf_comp: next_gain[5],
                         mf_gain: next_gain[4], torque_filt: next_gain[3],
                         pos_gain: next_gain[2], speed_integ: next_gain[1],
                         speed_gain: next_gain[0]};

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_active_gains <= '{friction_gain: `SGS_RST_FRICTION, mf_comp: `SGS_RST_MF_COMP,
                          mf_gain: `SGS_RST_MF_GAIN, torque_filt: `SGS_RST_TORQUE_FILT,
                          pos_gain: `SGS_RST_POS_GAIN, speed_integ: `SGS_RST_SPEED_INTEG,
                          speed_gain: `SGS_RST_SPEED_GAIN};
      o_set2_active  <= 1'b0;
      o_ramping      <= 1'b0;
    end else begin
      o_active_gains <= next_active;
      o_set2_active  <= (auto_on && in_ramp) ? !ramp_from : cur_set;
      o_ramping      <= auto_on && in_ramp;
    end
  end

endmodule

/* tb/sgs_switcher_properties.sv */
`timescale 1ns/1ps
module sgs_switcher_properties (
  input wire logic                  i_mclk,
  input wire logic                  i_rst,
  input wire logic                  i_s_axi_awvalid,
  input wire logic                  i_s_axi_wvalid,
  input wire logic                  i_s_axi_bready,
  input wire logic                  i_s_axi_arvalid,
  input wire logic                  i_s_axi_rready,
  input wire logic                  o_s_axi_bvalid,
  input wire logic                  o_s_axi_arready,
  input wire logic                  o_s_axi_rvalid,
  input wire logic [31:0]           o_s_axi_rdata,
  input wire logic                  i_cmd_busy,
  input wire logic                  i_motor_stopped,
  input wire logic                  i_position_ctrl,
  input wire logic [1:0]            i_loop_structure_select,
  input wire sgs_pkg::sgs_gain_set_t o_active_gains,
  input wire logic                  o_ramping
);
  import sgs_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_write_answer: assert property (
    i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid |=> o_s_axi_bvalid)
    else $error("write not answered");
  a_write_resp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write response dropped early");
  a_write_resp_retire: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
    else $error("write response not retired");
  a_read_answer: assert property (i_s_axi_arvalid && !o_s_axi_rvalid |=> o_s_axi_rvalid)
    else $error("read not answered");
  a_read_data_hold: assert property (
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data not held");
  a_read_busy_block: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read accepted while busy");
  a_ramp_needs_auto: assert property (
    $rose(o_ramping) |-> $past(i_position_ctrl) && ($past(i_loop_structure_select) < 2'h2))
    else $error("ramp outside allowed control");
  a_mf_needs_stop: assert property (
    $changed(o_active_gains.mf_gain) |-> $past(i_motor_stopped, 2) && !$past(i_cmd_busy, 2))
    else $error("model following gain moved while not stopped");
  a_mf_still_ramp: assert property (
    o_ramping |=> $stable(o_active_gains.mf_comp))
    else $error("model following compensation moved in ramp");
endmodule

bind sgs_switcher sgs_switcher_properties sgs_switcher_properties_i (
  .i_mclk, .i_rst, .i_s_axi_awvalid, .i_s_axi_wvalid, .i_s_axi_bready,
  .i_s_axi_arvalid, .i_s_axi_rready, .o_s_axi_bvalid, .o_s_axi_arready,
  .o_s_axi_rvalid, .o_s_axi_rdata, .i_cmd_busy, .i_motor_stopped, .i_position_ctrl,
  .i_loop_structure_select, .o_active_gains, .o_ramping);

/* tb/sgs_host_model.sv */
`timescale 1ns/1ps
module sgs_host_model (
  input  wire logic             i_mclk,
  input  wire logic [7:0]       i_cmd,
  output logic                  o_gain_sel,
  output logic                  o_cmd_busy,
  output logic                  o_motor_stopped,
  output logic                  o_position_ctrl,
  output sgs_pkg::sgs_pos_status_t o_pos_status
);
  import sgs_pkg::*;
  // Frame state lands on an edge, so the option bit never glitches mid-cycle
  logic [7:0] cmd_q = 8'h00;
  always @(posedge i_mclk) begin
    cmd_q <= i_cmd;
  end
  assign o_gain_sel      = cmd_q[7];
  assign o_cmd_busy      = cmd_q[6];
  assign o_motor_stopped = cmd_q[5];
  assign o_position_ctrl = cmd_q[4];
  assign o_pos_status    = cmd_q[3:0];
endmodule

/* tb/sgs_switcher_tb.sv */
`timescale 1ns/1ps
`include "sgs_defines.svh"
module sgs_switcher_tb;
  import sgs_pkg::*;
  localparam logic [15:0] SET1 [7] = '{`SGS_RST_SPEED_GAIN, `SGS_RST_SPEED_INTEG,
    `SGS_RST_POS_GAIN, `SGS_RST_TORQUE_FILT, `SGS_RST_MF_GAIN, `SGS_RST_MF_COMP,
    `SGS_RST_FRICTION};
  localparam logic [15:0] SET2 [7] = '{16'h0100, 16'h0200, 16'h0300, 16'h0400,
    16'h0500, 16'h0600, 16'h0700};
  localparam logic [3:0]  TRU [6]  = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h2, 4'h1};
  localparam logic [3:0]  FLS [6]  = '{4'h0, 4'h8, 4'h0, 4'h4, 4'h1, 4'h0};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] cmd = 8'h20;
  logic [1:0] loop_sel = 2'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic gain_sel, busy, stopped, pctrl, set2a, ramping;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  sgs_pos_status_t pstat;
  sgs_gain_set_t gains;
  int err_total = 0;
  int tests_run = 0;

  always #50 mclk = ~mclk;

  sgs_host_model sgs_host_model_i (.i_mclk(mclk), .i_cmd(cmd), .o_gain_sel(gain_sel),
    .o_cmd_busy(busy), .o_motor_stopped(stopped), .o_position_ctrl(pctrl),
    .o_pos_status(pstat));

  sgs_switcher #(.P_STEP_CYCLES(4)) sgs_switcher_i (.i_mclk(mclk), .i_rst(rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_gain_sel(gain_sel),
    .i_cmd_busy(busy), .i_motor_stopped(stopped), .i_position_ctrl(pctrl),
    .i_pos_status(pstat), .i_loop_structure_select(loop_sel), .o_active_gains(gains),
    .o_set2_active(set2a), .o_ramping(ramping));

  task automatic check(input logic [111:0] seen, input logic [111:0] want, input string what);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge mclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    // Late ready makes the slave hold its response for a cycle
    @(posedge mclk);
    bready <= 1'b1;
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b0;
    check(bresp, r, "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    @(posedge mclk);
    rready <= 1'b1;
    do @(posedge mclk); while (!rvalid);
    rready <= 1'b0;
    check(rdata, d, "rdata");
    check(rresp, r, "rresp");
  endtask

  // Model following pair follows m, everything else follows s
  function automatic sgs_gain_set_t want(input logic s, input logic m);
    logic [111:0] g;
    for (int i = 0; i < 7; i++) g[16*i +: 16] = s ? SET2[i] : SET1[i];
    g[64 +: 16] = m ? SET2[4] : SET1[4];
    g[80 +: 16] = m ? SET2[5] : SET1[5];
    return g;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(`SGS_OFS_CONFIG, 32'h0, `SGS_RESP_OKAY);
    rd(`SGS_OFS_WAIT2, 32'h0, `SGS_RESP_OKAY);
    for (int i = 0; i < 7; i++) rd(8'(`SGS_OFS_SET2_BASE + 4*i), SET1[i], 2'h0);
    rd(8'hfc, 32'h0, `SGS_RESP_SLVERR);
    check(gains, want(1'b0, 1'b0), "reset gains");
    $display("test reset done");
    for (int i = 0; i < 7; i++) wr(8'(`SGS_OFS_SET2_BASE + 4*i), SET2[i], 2'h0);
    wr(8'hfc, 16'h1234, `SGS_RESP_SLVERR);
    wr(`SGS_OFS_RAMP1, 16'h0004, `SGS_RESP_OKAY);
    wr(`SGS_OFS_WAIT1, 16'h0002, `SGS_RESP_OKAY);
    rd(`SGS_OFS_RAMP1, 32'h4, `SGS_RESP_OKAY);
    cmd <= 8'hc0;
    cyc(3);
    check(gains, want(1'b1, 1'b0), "busy switch");
    check(set2a, 1'b1, "select high");
    cmd <= 8'h20;
    cyc(3);
    check(gains, want(1'b0, 1'b0), "select low");
    // Model following pair lags one edge behind the rest
    cmd <= 8'ha0;
    cyc(4);
    check(gains, want(1'b1, 1'b1), "stopped switch");
    cmd <= 8'h20;
    cyc(4);
    check(gains, want(1'b0, 1'b0), "back to set 1");
    $display("test manual done");
    cmd <= 8'h30;
    wr(`SGS_OFS_CONFIG, 16'h0002, `SGS_RESP_OKAY);
    cyc(2);
    cmd <= 8'h38;
    cyc(7);
    check(ramping, 1'b0, "still waiting");
    do @(posedge mclk); while (!ramping);
    cyc(10);
    check(gains.pos_gain, 16'h0248, "ramp midpoint");
    do @(posedge mclk); while (ramping);
    cyc(2);
    check(gains, want(1'b1, 1'b0), "auto to set 2");
    cmd <= 8'h30;
    cyc(6);
    check(gains, want(1'b0, 1'b0), "auto to set 1");
    cmd <= 8'h38;
    cyc(3);
    cmd <= 8'h30;
    cyc(20);
    check({set2a, ramping}, 2'b00, "cancelled wait");
    $display("test auto done");
    wr(`SGS_OFS_WAIT1, 16'h0000, `SGS_RESP_OKAY);
    wr(`SGS_OFS_RAMP1, 16'h0000, `SGS_RESP_OKAY);
    for (int c = 0; c < 6; c++) begin
      cmd <= {4'h3, FLS[c]};
      wr(`SGS_OFS_CONFIG, 16'(c * 16 + 2), `SGS_RESP_OKAY);
      cyc(6);
      check(set2a, 1'b0, "condition false");
      cmd <= {4'h3, TRU[c]};
      cyc(6);
      check(set2a, 1'b1, "condition true");
      cmd <= {4'h2, TRU[c]};
      cyc(6);
      check(set2a, c[0], "fixed set");
      loop_sel <= 2'h2;
      cmd <= {4'h3, TRU[c]};
      cyc(6);
      check(set2a, c[0], "structure fixed");
      loop_sel <= 2'h0;
    end
    $display("test codes done");
    tally_and_finish();
  end
endmodule
